// File: verilog/ssmc_pkg.sv
// Constants and state codes for the sleep control of the synchronous burst memory.
// Assumes one 50 MHz core clock; every figure used by the logic is named here.
package ssmc_pkg;

    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned ENTRY_CYCLES = 2;
    localparam int unsigned SLEEP_RECOVERY_TIME_NS = 20;
    // Least time, so the cycle count rounds up and never falls below one.
    localparam int unsigned RECOVERY_CYCLES_RAW =
        (SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOVERY_CYCLES =
        (RECOVERY_CYCLES_RAW < 1) ? 1 : RECOVERY_CYCLES_RAW;

    localparam int unsigned TIMER_W = 4;
    localparam logic [TIMER_W-1:0] ENTRY_LOAD = TIMER_W'(ENTRY_CYCLES - 1);
    localparam logic [TIMER_W-1:0] RECOVERY_LOAD = TIMER_W'(RECOVERY_CYCLES - 1);

    localparam int unsigned ADDR_W = 20;
    localparam int unsigned DATA_W = 18;

    typedef enum logic [1:0] {
        SSMC_AWAKE = 2'b00,
        SSMC_ENTER = 2'b01,
        SSMC_ASLEEP = 2'b10,
        SSMC_RECOVER = 2'b11
    } ssmc_state_t;

endpackage : ssmc_pkg

// File: verilog/ssmc_cycle_timer.sv
// Small down counter used for the sleep entry delay and the recovery interval.
// Assumes the caller loads it one cycle before counting is needed.
`timescale 1ns/100ps
module ssmc_cycle_timer #(
    parameter int unsigned WIDTH = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_load_value,
    output logic o_done
);
    logic [WIDTH-1:0] count;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            count <= '0;
        end
        else if (i_load)
        begin
            count <= i_load_value;
        end
        else if (count != '0)
        begin
            count <= count - WIDTH'(1);
        end
    end

    assign o_done = (count == '0);

endmodule : ssmc_cycle_timer

// File: verilog/ssmc_sleep_ctrl.sv
// Sleep control and storage array of the synchronous burst memory.
// Assumes the controller and the sleep request share the 50 MHz core clock.
`timescale 1ns/100ps
module ssmc_sleep_ctrl #(
    parameter int unsigned ADDR_W = ssmc_pkg::ADDR_W,
    parameter int unsigned DATA_W = ssmc_pkg::DATA_W
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_sleep_request,
    input wire logic i_cmd_select,
    input wire logic i_cmd_write,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    output logic o_asleep,
    output logic o_ready,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_rdata_oe
);
    ssmc_pkg::ssmc_state_t state;
    ssmc_pkg::ssmc_state_t next_state;
    logic timer_load;
    logic [ssmc_pkg::TIMER_W-1:0] timer_value;
    logic timer_done;
    logic accept;
    logic mem_we;
    logic mem_re;
    logic [DATA_W-1:0] mem [0:(1 << ADDR_W)-1];

    ssmc_cycle_timer #(
        .WIDTH(ssmc_pkg::TIMER_W)
    ) u_timer (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_load(timer_load),
        .i_load_value(timer_value),
        .o_done(timer_done)
    );

    always_comb
    begin
        next_state = state;
        timer_load = 1'b0;
        timer_value = ssmc_pkg::ENTRY_LOAD;
        unique case (state)
            ssmc_pkg::SSMC_AWAKE:
            begin
                if (i_sleep_request)
                begin
                    // Once sampled high, entry is committed.
                    next_state = ssmc_pkg::SSMC_ENTER;
                    timer_load = 1'b1;
                end
            end
            ssmc_pkg::SSMC_ENTER:
            begin
                if (timer_done)
                begin
                    next_state = ssmc_pkg::SSMC_ASLEEP;
                end
            end
            ssmc_pkg::SSMC_ASLEEP:
            begin
                // No timeout: only the request falling or a reset ends sleep.
                if (!i_sleep_request)
                begin
                    next_state = ssmc_pkg::SSMC_RECOVER;
                    timer_load = 1'b1;
                    timer_value = ssmc_pkg::RECOVERY_LOAD;
                end
            end
            ssmc_pkg::SSMC_RECOVER:
            begin
                if (i_sleep_request)
                begin
                    next_state = ssmc_pkg::SSMC_ASLEEP;
                end
                else if (timer_done)
                begin
                    next_state = ssmc_pkg::SSMC_AWAKE;
                end
            end
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            state <= ssmc_pkg::SSMC_AWAKE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Asleep, all inputs but the request and reset are ignored and the part acts deselected.
    assign accept = i_cmd_select && (state != ssmc_pkg::SSMC_ASLEEP);
    // Writes are refused during recovery, relying on the controller not to send them.
    assign mem_we = accept && i_cmd_write && (state != ssmc_pkg::SSMC_RECOVER);
    assign mem_re = accept && !i_cmd_write;
    // The controller quiesces operations before the request rises.
    // Entry cycles still serve commands, but a read taken in the last entry cycle is not driven.

    // The array holds no reset, so contents survive sleep unchanged.
    always_ff @(posedge i_core_clk)
    begin
        if (mem_we)
        begin
            mem[i_addr] <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            o_rdata <= '0;
        end
        else if (mem_re)
        begin
            o_rdata <= mem[i_addr];
        end
    end

    // Drivers float whenever the next state is sleep, even for a read just taken.
    always_ff @(posedge i_core_clk)
    begin
        if (!i_rstn)
        begin
            o_rdata_oe <= 1'b0;
        end
        else
        begin
            o_rdata_oe <= mem_re && (next_state != ssmc_pkg::SSMC_ASLEEP);
        end
    end

    assign o_asleep = (state == ssmc_pkg::SSMC_ASLEEP);
    assign o_ready = (state == ssmc_pkg::SSMC_AWAKE) || (state == ssmc_pkg::SSMC_ENTER);

    // Each check stands down while reset is low.
    a_sleep_entry: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state == ssmc_pkg::SSMC_AWAKE) && i_sleep_request
        |=> !o_asleep ##1 !o_asleep ##1 o_asleep)
        else $error("Sleep not entered two cycles after request.");

    a_entry_ready: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state == ssmc_pkg::SSMC_ENTER) |-> o_ready && !o_asleep)
        else $error("Entry cycles stopped serving commands.");

    a_sleep_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_asleep && i_sleep_request |=> o_asleep)
        else $error("Sleep ended while request stayed high.");

    a_resleep: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state == ssmc_pkg::SSMC_RECOVER) && i_sleep_request |=> o_asleep)
        else $error("Request raised in recovery did not return to sleep.");

    a_recovery_wait: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_asleep && !i_sleep_request |=> !o_ready ##0 !o_asleep)
        else $error("Normal operation resumed without recovery interval.");

    a_recovery_end: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_asleep && !i_sleep_request ##1 !i_sleep_request |=> o_ready)
        else $error("Recovery took longer than its interval.");

    a_read_served: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state == ssmc_pkg::SSMC_AWAKE) && !i_sleep_request && i_cmd_select && !i_cmd_write
        |=> o_rdata_oe)
        else $error("Read while awake did not drive data.");

    a_outputs_float: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_asleep |-> !o_rdata_oe)
        else $error("Data drivers active while asleep.");

    a_asleep_not_ready: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_asleep |-> !o_ready)
        else $error("Ready shown while asleep.");

    a_asleep_no_access: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_asleep |-> !mem_we && !mem_re)
        else $error("Array accessed while asleep.");

    a_data_retained: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_asleep && $past(o_asleep) |-> $stable(o_rdata) && !mem_we)
        else $error("Contents or state changed during sleep.");

    a_rdata_held: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        $past(i_rstn) && !$past(mem_re) |-> $stable(o_rdata))
        else $error("Read data changed without a read.");

    a_ignore_inputs: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_asleep && i_cmd_select |=> !o_rdata_oe)
        else $error("Command served while asleep.");

    a_no_recover_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state == ssmc_pkg::SSMC_RECOVER) |-> !mem_we)
        else $error("Write accepted during recovery.");

    a_recovery_read: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state == ssmc_pkg::SSMC_RECOVER) && !i_sleep_request
        && i_cmd_select && !i_cmd_write |=> o_rdata_oe)
        else $error("Read during recovery was not served.");

    // Coverage of the main sleep scenarios.
    c_full_cycle: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_asleep ##1 !o_asleep && !o_ready ##1 o_ready);

    c_read_after_wake: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        $fell(o_asleep) ##[1:4] o_rdata_oe);

    c_resleep: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state == ssmc_pkg::SSMC_RECOVER) && i_sleep_request ##1 o_asleep);

    c_recover_read: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        (state == ssmc_pkg::SSMC_RECOVER) && mem_re ##1 o_rdata_oe);

    c_refused_write: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_asleep && i_cmd_select && i_cmd_write);

endmodule : ssmc_sleep_ctrl

// File: tb/ssmc_ctl_model.sv
// Memory controller model that drives the command and sleep inputs.
// Assumes the shared core clock; outputs change by NBA at rising edges.
`timescale 1ns/100ps
module ssmc_ctl_model (
    input wire logic i_core_clk,
    output logic o_sleep_request,
    output logic o_cmd_select,
    output logic o_cmd_write,
    output logic [ssmc_pkg::ADDR_W-1:0] o_addr,
    output logic [ssmc_pkg::DATA_W-1:0] o_wdata
);
    initial
    begin
        o_sleep_request = 1'b0;
        o_cmd_select = 1'b0;
        o_cmd_write = 1'b0;
        o_addr = '0;
        o_wdata = '0;
    end
    // A deselected bus shows inverted values so stale data cannot pass.
    task automatic cyc(input logic s, w, z, input logic [ssmc_pkg::ADDR_W-1:0] a,
        input logic [ssmc_pkg::DATA_W-1:0] d);
        @(posedge i_core_clk);
        o_sleep_request <= z;
        o_cmd_select <= s;
        o_cmd_write <= w;
        o_addr <= s ? a : ~o_addr;
        o_wdata <= s ? d : ~o_wdata;
    endtask : cyc
    task automatic idle(input logic z);
        cyc(1'b0, 1'b0, z, '0, '0);
    endtask : idle
    task automatic nap();
        idle(1'b0);
        idle(1'b1);
    endtask : nap
    task automatic wake();
        idle(1'b0);
        idle(1'b0);
    endtask : wake
    task automatic turn(input logic [ssmc_pkg::ADDR_W-1:0] a);
        cyc(1'b1, 1'b0, 1'b0, a, '0);
    endtask : turn
endmodule : ssmc_ctl_model

// File: tb/tb_sram_sleep_mode_control.sv
// Self-checking bench for the sleep control block.
// Assumes the controller model owns every command and sleep input.
`timescale 1ns/100ps
module tb_sram_sleep_mode_control;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic req, sel, wr, asleep, ready, oe;
    logic [ssmc_pkg::ADDR_W-1:0] addr;
    logic [ssmc_pkg::DATA_W-1:0] wdata, rdata;
    int failures = 0;
    int check_count = 0;
    always #10 clk = ~clk;
    ssmc_ctl_model ctl (.i_core_clk(clk), .o_sleep_request(req), .o_cmd_select(sel),
        .o_cmd_write(wr), .o_addr(addr), .o_wdata(wdata));
    ssmc_sleep_ctrl dut (.i_core_clk(clk), .i_rstn(rstn), .i_sleep_request(req),
        .i_cmd_select(sel), .i_cmd_write(wr), .i_addr(addr), .i_wdata(wdata),
        .o_asleep(asleep), .o_ready(ready), .o_rdata(rdata), .o_rdata_oe(oe));
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic t_rw();
        ctl.cyc(1'b1, 1'b1, 1'b0, 20'h00005, 18'h2A5A5);
        ctl.cyc(1'b1, 1'b0, 1'b0, 20'h00005, 18'h00000);
        ctl.turn(20'h00005);
        #1;
        chk(rdata, 18'h2A5A5);
        chk(18'(oe), 18'h00001);
        ctl.cyc(1'b1, 1'b1, 1'b0, 20'hFFFFF, 18'h15A5A);
        ctl.cyc(1'b1, 1'b0, 1'b0, 20'hFFFFF, 18'h00000);
        ctl.idle(1'b0);
        #1;
        chk(rdata, 18'h15A5A);
        ctl.idle(1'b0);
        #1;
        chk(18'(oe), 18'h00000);
        $display("test rw done");
    endtask : t_rw
    task automatic t_sleep();
        ctl.nap();
        ctl.idle(1'b1);
        ctl.idle(1'b1);
        #1;
        chk(18'(asleep), 18'h00000);
        ctl.idle(1'b1);
        #1;
        chk(18'(asleep), 18'h00001);
        ctl.cyc(1'b1, 1'b1, 1'b1, 20'h00005, 18'h3FFFF);
        ctl.cyc(1'b1, 1'b0, 1'b1, 20'h00005, 18'h00000);
        repeat (20)
        begin
            ctl.idle(1'b1);
            #1;
            chk(18'(oe), 18'h00000);
            chk(18'(asleep), 18'h00001);
        end
        ctl.idle(1'b0);
        ctl.cyc(1'b1, 1'b0, 1'b0, 20'h00005, 18'h00000);
        #1;
        chk(18'(asleep), 18'h00000);
        chk(18'(ready), 18'h00000);
        ctl.idle(1'b0);
        #1;
        chk(18'(ready), 18'h00001);
        chk(rdata, 18'h2A5A5);
        chk(18'(oe), 18'h00001);
        ctl.cyc(1'b1, 1'b0, 1'b0, 20'h00005, 18'h00000);
        ctl.idle(1'b0);
        #1;
        chk(rdata, 18'h2A5A5);
        $display("test sleep done");
    endtask : t_sleep
    task automatic t_reset();
        ctl.nap();
        repeat (3) ctl.idle(1'b1);
        #1;
        chk(18'(asleep), 18'h00001);
        ctl.idle(1'b0);
        ctl.idle(1'b1);
        #1;
        chk(18'(ready), 18'h00000);
        chk(18'(asleep), 18'h00000);
        ctl.idle(1'b1);
        #1;
        chk(18'(asleep), 18'h00001);
        ctl.idle(1'b0);
        rstn <= 1'b0;
        ctl.wake();
        rstn <= 1'b1;
        #1;
        chk(18'(asleep), 18'h00000);
        chk(18'(ready), 18'h00001);
        chk(rdata, 18'h00000);
        chk(18'(oe), 18'h00000);
        ctl.cyc(1'b1, 1'b0, 1'b0, 20'h00005, 18'h00000);
        ctl.idle(1'b0);
        #1;
        chk(rdata, 18'h2A5A5);
        chk(18'(oe), 18'h00001);
        $display("test reset done");
    endtask : t_reset
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk(18'(ready), 18'h00001);
        chk(18'(oe), 18'h00000);
        t_rw();
        t_sleep();
        t_reset();
        end_of_test();
    end
    // The tests need under a hundred cycles; 5000 cycles means a hang.
    initial
    begin
        #100000;
        failures++;
        end_of_test();
    end
endmodule : tb_sram_sleep_mode_control
